// ### verilog/scmi_params.svh
/*
  Constants of the sensor command interpreter: command codes, response
  bytes, reset values and timing. Assumes a 50 MHz core clock.
*/
`ifndef SCMI_PARAMS_SVH
`define SCMI_PARAMS_SVH

`define SCMI_CLK_MHZ 50
`define SCMI_RESP_US 100
`define SCMI_WRITE_MS 12
`define SCMI_WINDOW_MS 10
// least times, so rounded up; all are whole numbers at 50 MHz
`define SCMI_RESP_CYC (`SCMI_RESP_US * `SCMI_CLK_MHZ)
`define SCMI_WRITE_CYC (`SCMI_WRITE_MS * 1000 * `SCMI_CLK_MHZ)
// longest time, so rounded down
`define SCMI_WINDOW_CYC (`SCMI_WINDOW_MS * 1000 * `SCMI_CLK_MHZ)

`define SCMI_CMD_READ_HI 8'h1F
`define SCMI_CMD_WRITE_LO 8'h40
`define SCMI_CMD_WRITE_HI 8'h5F
`define SCMI_CMD_LEAVE 8'h80
`define SCMI_CMD_ENTER 8'hA0
`define SCMI_CMD_REV 8'hB0
`define SCMI_CFG_WORD 5'h1C
`define SCMI_ADDR_RST 7'h28
`define SCMI_CFG_RST 16'h0028
// status 10b (command mode) or 00b (normal), diagnostics 0000b, then response code
`define SCMI_RESP_BUSY 8'h80
`define SCMI_RESP_ACK 8'h81
`define SCMI_RESP_NACK 8'h82
`define SCMI_RESP_NORM 8'h00

`endif

// ### verilog/scmi_pkg.sv
/*
  Types of the sensor command interpreter.
  Assumes scmi_params.svh holds the numeric constants.
*/
package scmi_pkg;
  typedef enum logic [1:0] {
    SCMI_NORM = 2'h0,
    SCMI_CMD = 2'h1,
    SCMI_BUSY = 2'h3
  } scmi_state_t;

  typedef enum logic [1:0] {
    SCMI_OP_ENTER = 2'h0,
    SCMI_OP_READ = 2'h1,
    SCMI_OP_REV = 2'h2,
    SCMI_OP_WRITE = 2'h3
  } scmi_op_t;
endpackage : scmi_pkg

// ### verilog/scmi_eeprom.sv
/*
  Word store of 32 x 16 bits with registered read data.
  Assumes a single writer; the config word resets to its default.
*/
`timescale 1ns/1ns
`include "scmi_params.svh"

module scmi_eeprom
  import scmi_pkg::*;
#(
  parameter int WORDS = 32,
  parameter int AW = 5
)(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [AW-1:0] addr,
  input wire logic we,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata
);
  typedef struct packed {
    logic [WORDS-1:0][15:0] mem;
    logic [15:0] rd;
  } scmi_mem_t;

  scmi_mem_t s_q, s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.rd = s_q.mem[addr];
    if (we)
    begin
      s_d.mem[addr] = wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q <= '0;
      s_q.mem[`SCMI_CFG_WORD] <= `SCMI_CFG_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rd;
endmodule : scmi_eeprom

// ### verilog/scmi_core.sv
/*
  Command-mode interpreter of an I2C humidity sensor. Takes whole 4-byte
  command messages from a byte-level I2C slave front end,
  which matches the address given on slave_addr. Response bytes stand on
  resp_byte, data_hi, data_lo for the front end to shift out.
*/
// How it works
// RULE1: commands 0x00-0x1F with zero data read that word within 100 us.
// RULE2: command 0xB0 with zero data readies the revision word for a fetch.
// RULE3: commands 0x40-0x5F store both data bytes at the low bits, 12 ms.
// RULE4: command 0x80 with zero data leaves command mode for normal operation.
// RULE5: the enter command 0xA0 works only while the power-on window is open.
// RULE6: the host sends 0xA0 with zero data within 10 ms of power-on.
// RULE7: out of reset the device answers at slave address 0x28.
// RULE8: after a good entry the first fetched byte is 0x81.
// RULE9: on failed entry the host slows its bus below 100 kHz and retries.
// RULE10: reading word 0x1C gives 0x81 then 0x00 and 0x28 by default.
// RULE11: command 0x5C with 0x00 and a new address stores that address.
// RULE12: the host reads 0x1C back to confirm a new address.
// RULE13: each response is fetched by its own I2C read transfer.
// RULE14: on any failure the host power-cycles and starts over.
// RULE15: the slave address is bits 6:0 of configuration word 0x1C.
// RULE16: a new address takes effect only when command mode ends.
// RULE17: until a command completes, a fetch shows the busy response code.
`timescale 1ns/1ns
`include "scmi_params.svh"

module scmi_core
  import scmi_pkg::*;
#(
  parameter int RESP_CYC = `SCMI_RESP_CYC,
  parameter int WRITE_CYC = `SCMI_WRITE_CYC,
  parameter int WINDOW_CYC = `SCMI_WINDOW_CYC,
  // revision word, value is arbitrary
  parameter logic [15:0] REV_WORD = 16'h0001
)(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic msg_valid,
  input wire logic [7:0] msg_cmd,
  input wire logic [15:0] msg_data,
  output logic [6:0] slave_addr,
  output logic [7:0] resp_byte,
  output logic [7:0] data_hi,
  output logic [7:0] data_lo,
  output logic cmd_mode,
  output logic busy,
  output logic normal_start
);
  localparam int CW = 20;
  localparam logic [CW-1:0] RESP_N = CW'(RESP_CYC);
  localparam logic [CW-1:0] WRITE_N = CW'(WRITE_CYC);
  localparam logic [CW-1:0] WINDOW_N = CW'(WINDOW_CYC);

  typedef struct packed {
    scmi_state_t st;
    scmi_op_t op;
    logic [CW-1:0] cnt;
    logic [CW-1:0] win_cnt;
    logic win_open;
    logic [4:0] addr;
    logic [7:0] resp;
    logic [15:0] data;
    logic [6:0] slave_addr;
    logic [6:0] new_addr;
    logic nom;
    logic cm;
    logic bz;
  } scmi_core_t;

  scmi_core_t s_q, s_d;
  logic [15:0] mem_rdata;
  logic mem_we;
  logic zero_data;
  logic is_read;
  logic is_write;

  assign zero_data = (msg_data == 16'h0000);
  assign is_read = (msg_cmd <= `SCMI_CMD_READ_HI) && zero_data;
  assign is_write = (msg_cmd >= `SCMI_CMD_WRITE_LO)
                    && (msg_cmd <= `SCMI_CMD_WRITE_HI);

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_d = s_q;
    s_d.nom = 1'b0;
    mem_we = 1'b0;
    // window counter stops once closed, so it never wraps open again
    if (s_q.win_open)
    begin
      s_d.win_cnt = s_q.win_cnt + CW'(1);
      if (s_q.win_cnt == WINDOW_N - CW'(1))
      begin
        s_d.win_open = 1'b0;
      end
    end
    case (s_q.st)
      SCMI_NORM:
      begin
        // RULE5: entry gated by window
        if (msg_valid && s_q.win_open && msg_cmd == `SCMI_CMD_ENTER
            && zero_data)
        begin
          s_d.st = SCMI_BUSY;
          s_d.op = SCMI_OP_ENTER;
          s_d.cnt = RESP_N;
          s_d.resp = `SCMI_RESP_BUSY;
        end
      end
      SCMI_CMD:
      begin
        if (msg_valid)
        begin
          s_d.st = SCMI_BUSY;
          s_d.cnt = RESP_N;
          // RULE17: busy until done
          s_d.resp = `SCMI_RESP_BUSY;
          s_d.data = 16'h0000;
          if (is_read)
          begin
            // RULE1: word read
            s_d.op = SCMI_OP_READ;
            s_d.addr = msg_cmd[4:0];
          end
          else if (is_write)
          begin
            // RULE3: word write
            s_d.op = SCMI_OP_WRITE;
            s_d.addr = msg_cmd[4:0];
            s_d.cnt = WRITE_N;
            mem_we = 1'b1;
            // RULE11: stored address, RULE15: bits 6:0
            if (msg_cmd[4:0] == `SCMI_CFG_WORD)
            begin
              s_d.new_addr = msg_data[6:0];
            end
          end
          else if (msg_cmd == `SCMI_CMD_REV && zero_data)
          begin
            // RULE2: revision prepared
            s_d.op = SCMI_OP_REV;
          end
          else if (msg_cmd == `SCMI_CMD_LEAVE && zero_data)
          begin
            // RULE4: back to normal, RULE16: address applied now
            s_d.st = SCMI_NORM;
            s_d.slave_addr = s_q.new_addr;
            s_d.resp = `SCMI_RESP_NORM;
            s_d.nom = 1'b1;
          end
          else
          begin
            s_d.st = SCMI_CMD;
            s_d.resp = `SCMI_RESP_NACK;
          end
        end
      end
      SCMI_BUSY:
      begin
        // messages while busy are dropped
        s_d.cnt = s_q.cnt - CW'(1);
        if (s_q.cnt == CW'(1))
        begin
          s_d.st = SCMI_CMD;
          // RULE8: ack once in command mode
          s_d.resp = `SCMI_RESP_ACK;
          if (s_q.op == SCMI_OP_READ)
          begin
            // RULE10: response then high and low bytes
            s_d.data = mem_rdata;
          end
          else if (s_q.op == SCMI_OP_REV)
          begin
            s_d.data = REV_WORD;
          end
        end
      end
      default:
      begin
        s_d.st = SCMI_NORM;
      end
    endcase
    // mode flags registered so the outputs come straight from flops
    s_d.cm = (s_d.st != SCMI_NORM);
    s_d.bz = (s_d.st == SCMI_BUSY);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q <= '0;
      s_q.st <= SCMI_NORM;
      s_q.win_open <= 1'b1;
      // RULE7: default address
      s_q.slave_addr <= `SCMI_ADDR_RST;
      s_q.new_addr <= `SCMI_ADDR_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  scmi_eeprom #(.WORDS(32), .AW(5)) u_mem (
    .clk(clk),
    .arst_n(arst_n),
    .addr(mem_we ? msg_cmd[4:0] : s_q.addr),
    .we(mem_we),
    .wdata(msg_data),
    .rdata(mem_rdata)
  );

  assign slave_addr = s_q.slave_addr;
  assign resp_byte = s_q.resp;
  assign data_hi = s_q.data[15:8];
  assign data_lo = s_q.data[7:0];
  assign cmd_mode = s_q.cm;
  assign busy = s_q.bz;
  assign normal_start = s_q.nom;

  ////////////////////////////////////////////////////////////////////////
  sequence enter_seq;
    msg_valid && s_q.st == SCMI_NORM && s_q.win_open
      && msg_cmd == `SCMI_CMD_ENTER && zero_data;
  endsequence

  a_enter_goes_busy: assert property ( // RULE5
    @(posedge clk) disable iff (!arst_n)
    enter_seq |=> busy && resp_byte == `SCMI_RESP_BUSY)
    else $error("enter command not taken in window");
  a_enter_late_ignored: assert property ( // RULE5
    @(posedge clk) disable iff (!arst_n)
    msg_valid && !s_q.win_open && s_q.st == SCMI_NORM |=> !cmd_mode)
    else $error("enter command taken after window");
  a_busy_code_shown: assert property ( // RULE17
    @(posedge clk) disable iff (!arst_n)
    busy |-> resp_byte == `SCMI_RESP_BUSY)
    else $error("busy state without busy code");
  a_done_gives_ack: assert property ( // RULE8
    @(posedge clk) disable iff (!arst_n)
    busy && s_q.cnt == CW'(1) |=> !busy && cmd_mode
      && resp_byte == `SCMI_RESP_ACK)
    else $error("finished command not acknowledged");
  a_read_data_out: assert property ( // RULE1
    @(posedge clk) disable iff (!arst_n)
    busy && s_q.op == SCMI_OP_READ && s_q.cnt == CW'(1)
      |=> {data_hi, data_lo} == $past(mem_rdata))
    else $error("read word not presented");
  a_write_strobe: assert property ( // RULE3
    @(posedge clk) disable iff (!arst_n)
    msg_valid && s_q.st == SCMI_CMD && is_write
      |-> mem_we ##1 busy && s_q.cnt == WRITE_N)
    else $error("write not issued with write time");
  a_addr_held: assert property ( // RULE16
    @(posedge clk) disable iff (!arst_n)
    cmd_mode && $past(cmd_mode) |-> $stable(slave_addr))
    else $error("address changed inside command mode");
  a_leave_applies: assert property ( // RULE4
    @(posedge clk) disable iff (!arst_n)
    msg_valid && s_q.st == SCMI_CMD && msg_cmd == `SCMI_CMD_LEAVE
      && zero_data |=> !cmd_mode && normal_start
      && slave_addr == $past(s_q.new_addr) ##1 !normal_start)
    else $error("leave command did not apply address");
  a_cfg_addr_bits: assert property ( // RULE15
    @(posedge clk) disable iff (!arst_n)
    msg_valid && s_q.st == SCMI_CMD && msg_cmd == 8'h5C
      |=> s_q.new_addr == $past(msg_data[6:0]))
    else $error("config write did not capture address");
endmodule : scmi_core

// ### dv/scmi_host_model.sv
/*
  Host side of the command interpreter: sends whole 4-byte command
  messages as one-cycle valid pulses.
  Assumes the bench calls send() and samples the fetch outputs itself.
*/
`timescale 1ns/1ns

module scmi_host_model
  import scmi_pkg::*;
(
  input wire logic clk,
  output logic msg_valid,
  output logic [7:0] msg_cmd,
  output logic [15:0] msg_data
);
  initial
  begin
    msg_valid = 1'b0;
    msg_cmd = 8'h00;
    msg_data = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one whole message
  // idle bytes inverted so stale values are never mistaken for a command
  task automatic send(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk);
    msg_valid <= 1'b1;
    msg_cmd <= c;
    msg_data <= d;
    @(posedge clk);
    msg_valid <= 1'b0;
    msg_cmd <= ~c;
    msg_data <= ~d;
  endtask : send
endmodule : scmi_host_model

// ### dv/tb_sensor_command_mode_i2c.sv
/*
  Self-checking bench of the command interpreter with an integer model.
  Assumes shortened response, write and window counts.
*/
`timescale 1ns/1ns

module tb_sensor_command_mode_i2c;
  localparam int RC = 4;
  localparam int WC = 8;
  localparam int WN = 200;
  localparam logic [15:0] REV = 16'h0001;

  logic clk, arst_n, msg_valid, cmd_mode, busy, normal_start;
  logic [7:0] msg_cmd, resp_byte, data_hi, data_lo;
  logic [15:0] msg_data;
  logic [6:0] slave_addr;
  int failures, checks_done, cur_addr, new_addr, a, v;
  int mem [32];
  bit in_cmd, win_ok;

  scmi_core #(.RESP_CYC(RC), .WRITE_CYC(WC), .WINDOW_CYC(WN),
    .REV_WORD(REV)) dut_u (.clk(clk), .arst_n(arst_n),
    .msg_valid(msg_valid), .msg_cmd(msg_cmd), .msg_data(msg_data),
    .slave_addr(slave_addr), .resp_byte(resp_byte), .data_hi(data_hi),
    .data_lo(data_lo), .cmd_mode(cmd_mode), .busy(busy),
    .normal_start(normal_start));
  scmi_host_model host_u (.clk(clk), .msg_valid(msg_valid),
    .msg_cmd(msg_cmd), .msg_data(msg_data));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_cyc(input int got, input int exp);
    checks_done++;
    if (got != exp)
    begin
      failures++;
      $display("[FAIL] t=%0t cycles got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_cyc

  task report_and_stop;
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  task automatic do_reset;
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    in_cmd = 1'b0;
    cur_addr = 'h28;
    new_addr = 'h28;
    foreach (mem[i]) mem[i] = 0;
    mem['h1C] = 'h28;
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////
  // one command through the model; poke sends a read while still busy
  task automatic run(input int c, input int d, input bit poke);
    int r, w, cyc, n;
    bit lv;
    r = in_cmd ? 'h82 : 0;
    w = -1;
    cyc = 0;
    lv = 1'b0;
    if (!in_cmd)
    begin
      if (c == 'hA0 && d == 0 && win_ok)
      begin
        r = 'h81;
        cyc = RC;
        in_cmd = 1'b1;
      end
    end
    else if (c <= 'h1F && d == 0)
    begin
      r = 'h81;
      w = mem[c];
      cyc = RC;
    end
    else if (c >= 'h40 && c <= 'h5F)
    begin
      mem[c & 'h1F] = d;
      r = 'h81;
      cyc = WC;
      if ((c & 'h1F) == 'h1C)
        new_addr = d & 'h7F;
    end
    else if (c == 'hB0 && d == 0)
    begin
      r = 'h81;
      w = REV;
      cyc = RC;
    end
    else if (c == 'h80 && d == 0)
    begin
      r = 0;
      in_cmd = 1'b0;
      cur_addr = new_addr;
      lv = 1'b1;
    end
    host_u.send(8'(c), 16'(d));
    if (poke)
      host_u.send(8'h05, 16'h0000);
    #1;
    if (cyc > 0)
    begin
      chk(busy, 16'h0001);
      chk(resp_byte, 16'h0080);
      n = poke ? 2 : 0;
      while (busy === 1'b1 && n < 40)
      begin
        @(posedge clk);
        #1;
        n++;
      end
      chk_cyc(n, cyc);
    end
    chk(resp_byte, 16'(r));
    if (w >= 0)
      chk({data_hi, data_lo}, 16'(w));
    chk(cmd_mode, 16'(in_cmd));
    chk(slave_addr, 16'(cur_addr));
    chk(normal_start, 16'(lv));
  endtask : run

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    arst_n = 1'b0;
    failures = 0;
    checks_done = 0;
    win_ok = 1'b1;
    void'($urandom(32'h5daf268a));
    do_reset;
    @(posedge clk);
    #1;
    chk(slave_addr, 16'h0028);
    chk(resp_byte, 16'h0000);
    run('hA0, 'h0001, 0);
    run('hA0, 0, 0);
    run('h1C, 0, 0);
    run('h1C, 'h0100, 0);
    run('h20, 0, 0);
    run('hB0, 0, 0);
    $display("test entry and reads done");
    for (int i = 0; i < 4; i++)
    begin
      a = $urandom_range(31, 0);
      if (a == 'h1C)
        a = 'h1D;
      v = $urandom_range(16'hFFFF, 0);
      run('h40 | a, v, i == 0);
      run(a, 0, 0);
    end
    $display("test eeprom done");
    run('h5C, 'h0031, 0);
    run('h1C, 0, 0);
    run('h80, 0, 0);
    @(posedge clk);
    #1;
    chk(normal_start, 16'h0000);
    $display("test address change done");
    @(posedge clk);
    do_reset;
    repeat (WN + 5) @(posedge clk);
    win_ok = 1'b0;
    run('hA0, 0, 0);
    $display("test late entry done");
    report_and_stop;
  end

  // whole run is well under a thousand cycles
  initial
  begin
    #100000;
    failures++;
    $display("watchdog expired");
    report_and_stop;
  end
endmodule : tb_sensor_command_mode_i2c
